// ### rtl/pkwd_pkg.sv
// constants and types shared by the pin kicked watchdog
package pkwd_pkg;

  // reference clock
  localparam int unsigned CLK_MHZ = 125;

  // variant codes: 0 short, 1..3 longer timeouts
  localparam logic [1:0] VAR_SHORT = 2'h0;
  localparam logic [1:0] VAR_MID = 2'h1;
  localparam logic [1:0] VAR_LONG = 2'h2;
  localparam logic [1:0] VAR_XLONG = 2'h3;

  // timeout periods per variant in microseconds
  localparam int unsigned TWD_US [4] = '{3400, 6300, 102000, 1600000};

  // alarm hold time of the longer variants in microseconds
  localparam int unsigned HOLD_US = 210000;

  // least alarm pulse width in microseconds
  localparam int unsigned MIN_PULSE_US = 10;

  // glitch rejection time of both inputs in nanoseconds
  localparam int unsigned GLITCH_NS = 100;

  // derived cycle counts (least times round up)
  localparam int unsigned MIN_PULSE_CYC = MIN_PULSE_US * CLK_MHZ;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_CYC = HOLD_US * CLK_MHZ;

  // counter widths
  localparam int unsigned CNT_W = 28;
  localparam int unsigned FLT_W = 4;

  // reset values
  localparam logic ALARM_N_RST = 1'b1;
  localparam logic PIN_RST = 1'b0;

  // timeout in cycles for a variant code
  function automatic int unsigned twd_cycles(input logic [1:0] variant);
    twd_cycles = TWD_US[variant] * CLK_MHZ;
  endfunction

  // watchdog phases
  typedef enum logic [0:0] {
    ST_WATCH = 1'b0,
    ST_ALARM = 1'b1
  } pkwd_state_t;

endpackage

// ### rtl/pkwd_deglitch.sv
// input synchroniser with glitch filter and edge pulses
`timescale 1ns/100ps
module pkwd_deglitch (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // raw pin
  input wire logic pin_in,
  // filtered level and one-cycle edge pulses
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  localparam logic [pkwd_pkg::FLT_W-1:0] FLT_LAST =
    pkwd_pkg::FLT_W'(pkwd_pkg::GLITCH_CYC - 1);

  logic sync1_ff;
  logic sync2_ff;
  logic level_ff;
  logic rise_ff;
  logic fall_ff;
  logic [pkwd_pkg::FLT_W-1:0] stab_ff;
  logic take;

  // two flop synchroniser, reset to the idle pin level
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= pkwd_pkg::PIN_RST;
      sync2_ff <= pkwd_pkg::PIN_RST;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // a new level is taken only after it held for the whole filter time
  assign take = (sync2_ff != level_ff) && (stab_ff == FLT_LAST);

  // stability counter restarts whenever the input returns
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stab_ff <= '0;
    end else if (sync2_ff == level_ff || take) begin
      stab_ff <= '0;
    end else begin
      stab_ff <= stab_ff + 1'b1;
    end
  end

  // filtered level and its edges
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= pkwd_pkg::PIN_RST;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      if (take) begin
        level_ff <= sync2_ff;
      end
      rise_ff <= take && sync2_ff;
      fall_ff <= take && !sync2_ff;
    end
  end

  assign level_o = level_ff;
  assign rise_o = rise_ff;
  assign fall_o = fall_ff;

  // filtered level moves only after a full stable run
  a_glitch_reject: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (level_ff != $past(level_ff)) |-> $past(stab_ff) == FLT_LAST
  ) else $error("filtered level moved before filter time");

endmodule

// ### rtl/pkwd_top.sv
// pin kicked watchdog timer with filtered kick and inhibit inputs
// Functional notes
// - one fixed variant: 3.4/6.3/102 ms or 1.6 s
// - every alarm edge clears the counter
// - valid inhibit pulse clears the counter
// - rise clears always; fall only longer variants
// - kick pulses over 100 ns taken, short glitches dropped
// - constant kick makes alarm toggle repeatedly
// - counting starts at power-up; timeout drives alarm
// - longer variants hold alarm, ignoring kick
// - short variant alarm 10 us to timeout
// - alarm active low, open drain or push-pull
// - high inhibit suspends the watchdog
// - early inhibit: alarm high through inhibit plus timeout
// - inhibit releases alarm after 10 us least
// - inhibit pulses over 100 ns taken, glitches dropped
// - inhibit idles enabled through a pull-down
`timescale 1ns/100ps
module pkwd_top #(
  parameter logic [1:0] VARIANT = pkwd_pkg::VAR_SHORT,
  parameter bit OPEN_DRAIN = 1'b1,
  parameter int unsigned TWD_CYC = pkwd_pkg::twd_cycles(VARIANT),
  parameter int unsigned HOLD_CYC = pkwd_pkg::HOLD_CYC
) (
  // clock and power-on reset (supply above threshold)
  input wire logic ref_clk,
  input wire logic arst_n,
  // host side pins
  input wire logic kick_in,
  input wire logic inhibit_in,
  // alarm pin, split into level and enable
  output logic alarm_out_n,
  output logic alarm_oe,
  // observation of the watchdog phase
  output logic alarm_active
);

  // short variant differs in edge use and alarm length
  localparam bit IS_SHORT = (VARIANT == pkwd_pkg::VAR_SHORT);

  localparam logic [pkwd_pkg::CNT_W-1:0] TWD_LAST =
    pkwd_pkg::CNT_W'(TWD_CYC - 1);
  localparam logic [pkwd_pkg::CNT_W-1:0] HOLD_LAST =
    pkwd_pkg::CNT_W'(HOLD_CYC - 1);
  localparam logic [pkwd_pkg::CNT_W-1:0] MIN_LAST =
    pkwd_pkg::CNT_W'(pkwd_pkg::MIN_PULSE_CYC - 1);

  pkwd_pkg::pkwd_state_t state_ff;
  pkwd_pkg::pkwd_state_t nxt_state;
  logic [pkwd_pkg::CNT_W-1:0] cnt_ff;
  logic [pkwd_pkg::CNT_W-1:0] nxt_cnt;
  logic alarm_n_ff;
  logic nxt_alarm_n;
  logic seen_ff;
  logic nxt_seen;
  logic oe_ff;

  logic kick_rise;
  logic kick_fall;
  logic inh_lvl;
  logic kick_clr;
  logic min_done;
  logic release_now;

  // kick pin: synchronised and filtered before any use
  pkwd_deglitch u_kick_flt (
    .ref_clk (ref_clk),
    .arst_n (arst_n),
    .pin_in (kick_in),
    .level_o (),
    .rise_o (kick_rise),
    .fall_o (kick_fall)
  );

  // inhibit pin: floating pin reads low, filter resets to enabled
  pkwd_deglitch u_inh_flt (
    .ref_clk (ref_clk),
    .arst_n (arst_n),
    .pin_in (inhibit_in),
    .level_o (inh_lvl),
    .rise_o (),
    .fall_o ()
  );

  // kick edges that restart the timeout for this variant
  assign kick_clr = kick_rise || (!IS_SHORT && kick_fall);

  // least alarm width reached
  assign min_done = (cnt_ff >= MIN_LAST);

  // end of the alarm phase
  always_comb begin
    if (inh_lvl) begin
      release_now = min_done;
    end else if (IS_SHORT) begin
      release_now = (cnt_ff == TWD_LAST) ||
                    (min_done && (seen_ff || kick_rise));
    end else begin
      release_now = (cnt_ff == HOLD_LAST);
    end
  end

  // next phase, count and alarm level
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_alarm_n = alarm_n_ff;
    nxt_seen = seen_ff;
    unique case (state_ff)
      pkwd_pkg::ST_WATCH: begin
        nxt_seen = 1'b0;
        if (inh_lvl) begin
          nxt_cnt = '0;
        end else if (kick_clr) begin
          nxt_cnt = '0;
        end else if (cnt_ff == TWD_LAST) begin
          nxt_state = pkwd_pkg::ST_ALARM;
          nxt_alarm_n = 1'b0;
          nxt_cnt = '0;
        end
      end
      pkwd_pkg::ST_ALARM: begin
        if (release_now) begin
          nxt_state = pkwd_pkg::ST_WATCH;
          nxt_alarm_n = 1'b1;
          nxt_cnt = '0;
          nxt_seen = 1'b0;
        end else if (IS_SHORT && kick_rise) begin
          nxt_seen = 1'b1; // early kick ends alarm at 10 us
        end
      end
    endcase
  end

  // phase register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= pkwd_pkg::ST_WATCH;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // interval counter, starts from zero at reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // alarm level and remembered kick of the short variant
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_n_ff <= pkwd_pkg::ALARM_N_RST;
      seen_ff <= 1'b0;
    end else begin
      alarm_n_ff <= nxt_alarm_n;
      seen_ff <= nxt_seen;
    end
  end

  // pin enable: open drain drives only while low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_ff <= !OPEN_DRAIN;
    end else begin
      oe_ff <= OPEN_DRAIN ? !nxt_alarm_n : 1'b1;
    end
  end

  // open drain pulls low only; push-pull drives the level
  assign alarm_out_n = OPEN_DRAIN ? 1'b0 : alarm_n_ff;
  assign alarm_oe = oe_ff;
  assign alarm_active = !alarm_n_ff;

  // checks on the watchdog phases

  // counter reaches timeout with nothing clearing it
  sequence s_timeout_hit;
    state_ff == pkwd_pkg::ST_WATCH && cnt_ff == TWD_LAST &&
      !inh_lvl && !kick_clr;
  endsequence

  // alarm freshly asserted with a cleared counter
  sequence s_alarm_start;
    !alarm_n_ff && state_ff == pkwd_pkg::ST_ALARM && cnt_ff == '0;
  endsequence

  // alarm phase still inside its least width
  sequence s_alarm_young;
    state_ff == pkwd_pkg::ST_ALARM && cnt_ff < MIN_LAST;
  endsequence

  // short alarm at its least width with a kick already seen
  sequence s_short_kicked;
    IS_SHORT && state_ff == pkwd_pkg::ST_ALARM && !inh_lvl &&
      cnt_ff == MIN_LAST && (seen_ff || kick_rise);
  endsequence

  // an unkicked timeout must start a fresh alarm
  property p_timeout_alarm;
    @(posedge ref_clk) disable iff (!arst_n)
    s_timeout_hit |=> s_alarm_start;
  endproperty

  a_timeout_fires: assert property (p_timeout_alarm)
    else $error("timeout did not assert alarm");

  // both alarm edges restart the interval
  a_edge_clears: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (alarm_n_ff != $past(alarm_n_ff)) |-> cnt_ff == '0
  ) else $error("alarm edge left counter running");

  // inhibit keeps the watch counter at zero
  a_inhibit_clears: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (inh_lvl && state_ff == pkwd_pkg::ST_WATCH) |=>
      cnt_ff == '0 && alarm_n_ff
  ) else $error("inhibit did not hold counter clear");

  // a rising kick always restarts the timeout
  a_kick_clears: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state_ff == pkwd_pkg::ST_WATCH && kick_rise) |=> cnt_ff == '0
  ) else $error("rising kick did not clear counter");

  // a falling kick restarts only the longer variants
  a_fall_use: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state_ff == pkwd_pkg::ST_WATCH && kick_fall && !kick_rise &&
     !inh_lvl && cnt_ff != TWD_LAST) |=>
      (IS_SHORT ? cnt_ff == $past(cnt_ff) + 1'b1 : cnt_ff == '0)
  ) else $error("falling kick handled wrongly for variant");

  // longer variants keep the alarm for the whole hold
  a_hold_ignores: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (!IS_SHORT && state_ff == pkwd_pkg::ST_ALARM && !inh_lvl &&
     cnt_ff != HOLD_LAST) |=> !alarm_n_ff
  ) else $error("alarm left hold early");

  // alarm ends when its interval runs out
  a_hold_ends: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state_ff == pkwd_pkg::ST_ALARM &&
     cnt_ff == (IS_SHORT ? TWD_LAST : HOLD_LAST)) |=>
      alarm_n_ff && cnt_ff == '0
  ) else $error("alarm phase overran its interval");

  // no alarm pulse is cut below the least width
  a_min_width: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s_alarm_young |=> !alarm_n_ff
  ) else $error("alarm pulse shorter than least width");

  // inhibit releases an alarm once the least width passed
  a_inhibit_rel: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (inh_lvl && state_ff == pkwd_pkg::ST_ALARM && min_done) |=>
      alarm_n_ff
  ) else $error("inhibit did not release alarm");

  // short alarm never outlasts one timeout
  a_short_max: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (IS_SHORT && state_ff == pkwd_pkg::ST_ALARM) |-> cnt_ff <= TWD_LAST
  ) else $error("short alarm longer than timeout");

  // pin level and enable follow the output style
  a_pin_drive: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    OPEN_DRAIN ? (alarm_oe == !alarm_n_ff && !alarm_out_n)
               : (alarm_oe && alarm_out_n == alarm_n_ff)
  ) else $error("alarm pin drive does not match style");

  // a kick seen by the least width ends the short alarm there
  a_kick_ends: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s_short_kicked |=> alarm_n_ff && state_ff == pkwd_pkg::ST_WATCH
  ) else $error("kicked short alarm not ended at least width");

  // watch counter advances by one when nothing clears it
  a_count_runs: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state_ff == pkwd_pkg::ST_WATCH && !inh_lvl && !kick_clr &&
     cnt_ff != TWD_LAST) |=> cnt_ff == $past(cnt_ff) + 1'b1
  ) else $error("watch counter did not advance");

  // kicks during the long hold leave the hold count running
  a_hold_kick: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (!IS_SHORT && state_ff == pkwd_pkg::ST_ALARM && !inh_lvl &&
     kick_clr && cnt_ff != HOLD_LAST) |=> cnt_ff == $past(cnt_ff) + 1'b1
  ) else $error("kick disturbed the alarm hold");

  // no alarm can start while inhibit holds the watch phase
  a_inhibit_quiet: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (inh_lvl && state_ff == pkwd_pkg::ST_WATCH) |=>
      state_ff == pkwd_pkg::ST_WATCH
  ) else $error("alarm started under inhibit");

endmodule

// ### bench/pkwd_host_mdl.sv
// host model that drives the kick pin
`timescale 1ns/100ps
module pkwd_host_mdl (
  // clock
  input wire logic ref_clk,
  // control from the bench
  input wire logic auto_en,
  input wire logic kick_req,
  // kick pin
  output logic kick_in
);
  logic tgl_ff = 1'b0;
  int cnt_ff = 0;
  // flip the kick level every 1000 cycles
  always_ff @(posedge ref_clk) begin
    cnt_ff <= (cnt_ff >= 999) ? 0 : cnt_ff + 1;
    if (cnt_ff >= 999) begin
      tgl_ff <= ~tgl_ff;
    end
  end
  // rise every 2000 cycles, inside the timeout
  assign kick_in = auto_en ? tgl_ff : kick_req;
endmodule

// ### bench/pkwd_top_bench.sv
// self-checking bench for the pin kicked watchdog
`timescale 1ns/100ps
module pkwd_top_bench;
  localparam int TWD = 3000;
  localparam int HOLD = 2000;
  localparam int MINP = 1250;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic inhibit_in = 1'b0; // floating pin resolves low
  logic auto_en = 1'b0;
  logic kick_req = 1'b0;
  logic kick_in;
  logic [1:0] out_n;
  logic [1:0] oe;
  logic [1:0] act;
  logic [1:0] pin;
  logic [5:0] rst_snap;
  int n_mismatch = 0;
  int n_checks = 0;

  // short open-drain and mid push-pull variants
  pkwd_top #(.VARIANT(pkwd_pkg::VAR_SHORT), .OPEN_DRAIN(1'b1),
    .TWD_CYC(TWD), .HOLD_CYC(HOLD)) i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .kick_in(kick_in),
    .inhibit_in(inhibit_in), .alarm_out_n(out_n[0]),
    .alarm_oe(oe[0]), .alarm_active(act[0]));
  pkwd_top #(.VARIANT(pkwd_pkg::VAR_MID), .OPEN_DRAIN(1'b0),
    .TWD_CYC(TWD), .HOLD_CYC(HOLD)) i_dut_l (
    .ref_clk(ref_clk), .arst_n(arst_n), .kick_in(kick_in),
    .inhibit_in(inhibit_in), .alarm_out_n(out_n[1]),
    .alarm_oe(oe[1]), .alarm_active(act[1]));
  pkwd_host_mdl i_host (.ref_clk(ref_clk), .auto_en(auto_en),
    .kick_req(kick_req), .kick_in(kick_in));

  // pin level with external pull-up
  assign pin = (oe & out_n) | ~oe;

  // clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  // cycle count compare, allowing for filter latency
  task automatic near(string nm, int seen, int exp);
    check(nm, (seen >= exp - 6 && seen <= exp + 6) ? exp : seen, exp);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    inhibit_in <= 1'b0;
    auto_en <= 1'b0;
    kick_req <= 1'b0;
    repeat (19) @(posedge ref_clk);
    #1;
    rst_snap = {act, oe, out_n};
    @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask

  // cycles until alarm, then cycles alarm lasts
  task automatic meas(int i, output int t_lo, output int t_len);
    t_lo = 0;
    t_len = 0;
    do begin
      @(posedge ref_clk);
      #1;
      t_lo++;
    end while (pin[i] !== 1'b0 && t_lo < 20000);
    do begin
      @(posedge ref_clk);
      #1;
      t_len++;
    end while (pin[i] === 1'b0 && t_len < 20000);
  endtask

  task automatic t_power_up();
    int a, b, c, d;
    do_reset();
    check("pins_in_reset", rst_snap, 6'h0a);
    fork
      meas(0, a, b);
      meas(1, c, d);
    join
    near("short_first", a, TWD);
    near("short_hold", b, TWD);
    near("long_first", c, TWD);
    near("long_hold", d, HOLD);
    meas(0, a, b);
    near("short_again", a, TWD);
  endtask

  task automatic t_kicked();
    logic low_seen;
    do_reset();
    auto_en <= 1'b1;
    low_seen = 1'b0;
    repeat (12000) begin
      @(posedge ref_clk);
      #1;
      if (pin !== 2'b11) low_seen = 1'b1;
    end
    check("kicked_no_alarm", low_seen, 1'b0);
  endtask

  task automatic t_glitch();
    int a, b, c, d;
    do_reset();
    fork
      meas(0, a, b);
      meas(1, c, d);
      repeat (7) begin
        repeat (400) @(posedge ref_clk);
        kick_req <= 1'b1;
        inhibit_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        kick_req <= 1'b0;
        inhibit_in <= 1'b0;
      end
    join
    near("glitch_ignored", a, TWD);
    near("glitch_ignored_l", c, TWD);
  endtask

  task automatic t_fall_edge();
    do_reset();
    kick_req <= 1'b1;
    repeat (2000) @(posedge ref_clk);
    kick_req <= 1'b0;
    repeat (1300) @(posedge ref_clk);
    #1;
    check("fall_ignored_short", pin[0], 1'b0);
    check("fall_clears_long", pin[1], 1'b1);
    check("active_flags", act, 2'b01);
  endtask

  task automatic t_kick_alarm();
    int a, b, c, d;
    do_reset();
    fork
      meas(0, a, b);
      meas(1, c, d);
      begin
        wait (pin[0] === 1'b0);
        repeat (100) @(posedge ref_clk);
        kick_req <= 1'b1;
      end
    join
    near("short_kicked", b, MINP);
    near("long_ignores", d, HOLD);
  endtask

  task automatic t_inhibit();
    int a, b, c, d;
    do_reset();
    repeat (100) @(posedge ref_clk);
    inhibit_in <= 1'b1;
    repeat (5000) @(posedge ref_clk);
    inhibit_in <= 1'b0;
    fork
      meas(0, a, b);
      meas(1, c, d);
      begin
        wait (pin[0] === 1'b0);
        repeat (100) @(posedge ref_clk);
        inhibit_in <= 1'b1;
      end
    join
    near("inhibit_plus_twd", a, TWD + 16);
    near("inhibit_long", c, TWD + 16);
    near("inhibit_release", b, MINP);
    near("inhibit_release_l", d, MINP);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #800000;
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    t_power_up();
    $display("power_up done");
    t_kicked();
    $display("kicked done");
    t_glitch();
    $display("glitch done");
    t_fall_edge();
    $display("fall_edge done");
    t_kick_alarm();
    $display("kick_alarm done");
    t_inhibit();
    $display("inhibit done");
    finish_test();
  end
endmodule
